// [common/twi_pkg.sv]
/*
  Constants and types for the two-wire master transmit controller.
  Assumes a 125 MHz system clock and an AHB-Lite register port.
*/
package twi_pkg;

  // Register byte offsets
  localparam logic [7:0] TWI_OFS_CTRL = 8'h00;
  localparam logic [7:0] TWI_OFS_STAT = 8'h04;
  localparam logic [7:0] TWI_OFS_DATA = 8'h08;

  // Control register bit positions
  localparam int TWI_CB_IE = 0;
  localparam int TWI_CB_EN = 2;
  localparam int TWI_CB_WC = 3;
  localparam int TWI_CB_STO = 4;
  localparam int TWI_CB_STA = 5;
  localparam int TWI_CB_EA = 6;
  localparam int TWI_CB_INT = 7;

  // Status layout
  localparam int TWI_SB_CODE_LO = 3;
  localparam logic [7:0] TWI_DATA_RESET = 8'hFF;
  localparam logic [4:0] TWI_ST_IDLE = 5'h1F;
  localparam logic [4:0] TWI_ST_START = 5'h01;
  localparam logic [4:0] TWI_ST_ADDR_ACK = 5'h03;
  localparam logic [4:0] TWI_ST_ADDR_NACK = 5'h04;
  localparam logic [4:0] TWI_ST_DATA_ACK = 5'h05;
  localparam logic [4:0] TWI_ST_DATA_NACK = 5'h06;

  // Bus timing: quarter bit period
  localparam int TWI_CLK_MHZ = 125;
  localparam int TWI_QUARTER_NS = 2500;
  localparam int TWI_QUARTER_CYC = (TWI_QUARTER_NS * TWI_CLK_MHZ) / 1000;
  localparam logic [9:0] TWI_QUARTER_LAST = 10'(TWI_QUARTER_CYC - 1);

  localparam logic [1:0] TWI_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    TWI_S_IDLE = 3'h0,
    TWI_S_START = 3'h1,
    TWI_S_BIT = 3'h2,
    TWI_S_STOP = 3'h3,
    TWI_S_HOLD = 3'h4
  } twi_state_t;

endpackage

// [core/twi_sync.sv]
/*
  Two-flop synchroniser for one pin level.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/100ps
module twi_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Level
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic first;
    logic second;
  } twi_sync_t;

  twi_sync_t r;
  twi_sync_t next_r;

  always_comb begin
    next_r.first = din;
    next_r.second = r.first;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= 2'h3;
    end else begin
      r <= next_r;
    end
  end

  assign dout = r.second;

endmodule

// [core/twi_master_tx.sv]
/*
  Byte-oriented two-wire master transmitter with a software handshake.
  Assumes an AHB-Lite master on ref_clk and open-drain pad logic outside.
*/
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps

module twi_master_tx (
  // System
  input wire logic ref_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Two-wire pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt request
  output logic op_done_irq
);

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic done;
    logic ea;
    logic sta;
    logic sto;
    logic data_write_collision;
    logic en;
    logic op_done_irq_enable;
    logic [4:0] code;
    logic [1:0] bit_rate_prescale;
    logic [7:0] serial_shift_data;
    twi_pkg::twi_state_t state;
    logic [1:0] phase;
    logic [9:0] tick;
    logic [3:0] bitn;
    logic is_addr;
    logic scl_low;
    logic sda_low;
    logic irq;
  } twi_mtx_t;

  twi_mtx_t r;
  twi_mtx_t next_r;
  logic sda_s;
  logic scl_s;

  twi_sync u_sda_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .din(sda_in),
    .dout(sda_s)
  );

  // Clock stretching by the slave is not followed; line level is sampled only
  twi_sync u_scl_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .din(scl_in),
    .dout(scl_s)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [7:0] wb;
    logic launch;
    logic tick_end;
    wb = 8'h00;
    launch = 1'b0;
    tick_end = (r.tick == twi_pkg::TWI_QUARTER_LAST);
    next_r = r;
    next_r.tick = tick_end ? 10'h000 : r.tick + 10'h001;

    // Address phase capture
    next_r.wr_pend = 1'b0;
    if (hsel && hready && htrans == twi_pkg::TWI_HTRANS_NONSEQ) begin
      next_r.wr_pend = hwrite;
      next_r.wr_addr = haddr;
      next_r.hrdata = 32'h0000_0000;
      if (!hwrite) begin
        if (haddr == twi_pkg::TWI_OFS_CTRL) begin
          next_r.hrdata[7:0] = {r.done, r.ea, r.sta, r.sto, r.data_write_collision,
                                r.en, 1'b0, r.op_done_irq_enable};
        end else if (haddr == twi_pkg::TWI_OFS_STAT) begin
          next_r.hrdata[7:0] = {r.code, 1'b0, r.bit_rate_prescale};
        end else if (haddr == twi_pkg::TWI_OFS_DATA) begin
          next_r.hrdata[7:0] = r.serial_shift_data;
        end
      end
    end

    // Data phase write
    if (r.wr_pend) begin
      wb = hwdata[7:0];
      if (r.wr_addr == twi_pkg::TWI_OFS_CTRL) begin
        next_r.ea = wb[twi_pkg::TWI_CB_EA];
        next_r.sta = wb[twi_pkg::TWI_CB_STA];
        next_r.sto = wb[twi_pkg::TWI_CB_STO];
        next_r.en = wb[twi_pkg::TWI_CB_EN];
        next_r.op_done_irq_enable = wb[twi_pkg::TWI_CB_IE];
        if (wb[twi_pkg::TWI_CB_INT]) begin
          next_r.done = 1'b0;
          launch = 1'b1;
        end
      end else if (r.wr_addr == twi_pkg::TWI_OFS_STAT) begin
        next_r.bit_rate_prescale = wb[1:0];
      end else if (r.wr_addr == twi_pkg::TWI_OFS_DATA) begin
        if (r.done) begin
          next_r.serial_shift_data = wb;
          next_r.data_write_collision = 1'b0;
        end else begin
          next_r.data_write_collision = 1'b1;
        end
      end
    end

    // Bus sequencer
    case (r.state)
      twi_pkg::TWI_S_IDLE: begin
        if (launch && next_r.en) begin
          next_r.tick = 10'h000;
          next_r.phase = 2'h0;
          if (next_r.sta) begin
            next_r.state = twi_pkg::TWI_S_START;
          end else if (next_r.sto) begin
            next_r.state = twi_pkg::TWI_S_STOP;
          end else begin
            next_r.state = twi_pkg::TWI_S_BIT;
            next_r.bitn = 4'h0;
          end
        end
      end
      twi_pkg::TWI_S_HOLD: begin
        // Launch only once the flag is cleared
        next_r.scl_low = 1'b1;
        // The clearing write itself drops the flag, so test the next value
        if (launch && !next_r.done) begin
          next_r.tick = 10'h000;
          next_r.phase = 2'h0;
          if (next_r.sto) begin
            next_r.state = twi_pkg::TWI_S_STOP;
          end else if (next_r.sta) begin
            next_r.state = twi_pkg::TWI_S_START;
          end else begin
            next_r.state = twi_pkg::TWI_S_BIT;
            next_r.bitn = 4'h0;
          end
        end
      end
      twi_pkg::TWI_S_START: begin
        if (tick_end) begin
          next_r.phase = r.phase + 2'h1;
          case (r.phase)
            2'h0: begin
              next_r.sda_low = 1'b0;
              next_r.scl_low = 1'b0;
            end
            2'h1: next_r.sda_low = 1'b1;
            2'h2: next_r.scl_low = 1'b1;
            default: begin
              next_r.done = 1'b1;
              next_r.code = twi_pkg::TWI_ST_START;
              next_r.is_addr = 1'b1;
              next_r.sta = 1'b0;
              next_r.state = twi_pkg::TWI_S_HOLD;
            end
          endcase
        end
      end
      twi_pkg::TWI_S_BIT: begin
        // Bits 0..7 data, bit 8 acknowledge
        if (tick_end) begin
          next_r.phase = r.phase + 2'h1;
          case (r.phase)
            2'h0: next_r.sda_low = (r.bitn == 4'h8) ? 1'b0 : !r.serial_shift_data[7];
            2'h1: next_r.scl_low = 1'b0;
            2'h2: begin
              if (r.bitn != 4'h8) begin
                next_r.serial_shift_data = {r.serial_shift_data[6:0], sda_s};
              end
            end
            default: begin
              next_r.scl_low = 1'b1;
              next_r.bitn = r.bitn + 4'h1;
              if (r.bitn == 4'h8) begin
                next_r.done = 1'b1;
                next_r.is_addr = 1'b0;
                next_r.state = twi_pkg::TWI_S_HOLD;
                if (r.is_addr) begin
                  next_r.code = sda_s ? twi_pkg::TWI_ST_ADDR_NACK
                                      : twi_pkg::TWI_ST_ADDR_ACK;
                end else begin
                  next_r.code = sda_s ? twi_pkg::TWI_ST_DATA_NACK
                                      : twi_pkg::TWI_ST_DATA_ACK;
                end
              end
            end
          endcase
        end
      end
      twi_pkg::TWI_S_STOP: begin
        if (tick_end) begin
          next_r.phase = r.phase + 2'h1;
          case (r.phase)
            2'h0: next_r.sda_low = 1'b1;
            2'h1: next_r.scl_low = 1'b0;
            2'h2: next_r.sda_low = 1'b0;
            default: begin
              next_r.sto = 1'b0;
              next_r.code = twi_pkg::TWI_ST_IDLE;
              next_r.state = twi_pkg::TWI_S_IDLE;
            end
          endcase
        end
      end
      default: next_r.state = twi_pkg::TWI_S_IDLE;
    endcase

    // Switching off returns to idle and releases both lines at once; done and the irq are kept
    if (!next_r.en) begin
      next_r.state = twi_pkg::TWI_S_IDLE;
      next_r.scl_low = 1'b0;
      next_r.sda_low = 1'b0;
    end
    next_r.irq = next_r.done && next_r.op_done_irq_enable;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '0;
      r.code <= twi_pkg::TWI_ST_IDLE;
      r.serial_shift_data <= twi_pkg::TWI_DATA_RESET;
      r.state <= twi_pkg::TWI_S_IDLE;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Open drain: enable only while pulling low
  assign hrdata = r.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign scl_out = 1'b0;
  assign scl_oe = r.scl_low;
  assign sda_out = 1'b0;
  assign sda_oe = r.sda_low;
  assign op_done_irq = r.irq;

endmodule

// [dv/twmth_monitor.sv]
/* Assertions on the master transmitter ports.
   Assumes the bind below; software keeps the irq enable set. */
`timescale 1ns/100ps
module twmth_monitor (
  // Clock, reset, bus
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  // Pins
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic op_done_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic ctl;
  logic busy;
  logic byte_op;
  logic [13:0] cnt;
  logic stop_wait;
  logic [10:0] stop_cnt;
  wire go = ctl && hwdata[7] && hwdata[2];
  wire go_sta = go && hwdata[5] && !hwdata[4];
  wire go_sto = go && hwdata[4];
  // Control write in its data phase; cnt times the running operation
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctl <= 1'b0;
      busy <= 1'b0;
      byte_op <= 1'b0;
      cnt <= 14'h0000;
      stop_wait <= 1'b0;
      stop_cnt <= 11'h000;
    end else begin
      ctl <= hsel && hready && htrans == 2'h2 && hwrite && haddr == twi_pkg::TWI_OFS_CTRL;
      busy <= go ? !hwdata[4] : busy && !op_done_irq;
      byte_op <= go ? !hwdata[5] && !hwdata[4] : byte_op;
      cnt <= go ? 14'h0000 : cnt + 14'h0001;
      // Stop requested until both lines are released
      stop_wait <= go_sto || (stop_wait && (scl_oe || sda_oe));
      stop_cnt <= go_sto ? 11'h000 : stop_cnt + 11'h001;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_start; sda_oe && !scl_oe; endsequence
  property p_clear; go && op_done_irq |=> ##[0:2] !op_done_irq; endproperty
  a_clear: assert property (p_clear) else $error("flag kept after launch");
  property p_keep; ctl && !hwdata[7] && hwdata[0] && op_done_irq |=> op_done_irq [*3]; endproperty
  a_keep: assert property (p_keep) else $error("flag lost on zero write");
  property p_idle; op_done_irq [*3] |-> $stable(sda_oe); endproperty
  a_idle: assert property (p_idle) else $error("sda moved while flag set");
  property p_start; go_sta |-> ##[1:1000] s_start; endproperty
  a_start: assert property (p_start) else $error("no start condition");
  // 12500 cycles: longest operation is nine bits of four quarters
  property p_bound; busy |-> cnt < 14'h30D4; endproperty
  a_bound: assert property (p_bound) else $error("operation never done");
  property p_byte; $rose(op_done_irq) && byte_op |-> cnt > 14'h2328; endproperty
  a_byte: assert property (p_byte) else $error("byte done too early");
  // 1600 cycles: stop releases both lines after three quarters
  property p_stop; stop_wait |-> !op_done_irq && stop_cnt < 11'h640; endproperty
  a_stop: assert property (p_stop) else $error("stop not clean");
  property p_held; op_done_irq [*2] |-> scl_oe; endproperty
  a_held: assert property (p_held) else $error("scl free while flag set");
endmodule
bind twi_master_tx twmth_monitor u_mon (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .scl_oe(scl_oe), .sda_oe(sda_oe), .op_done_irq(op_done_irq));

// [dv/twmth_slave_model.sv]
/* Slave receiver on the two wires: captures bytes and answers ack, or no ack while nack is set.
   Assumes resolved wire levels with pull-ups. */
`timescale 1ns/100ps
module twmth_slave_model (
  // Wires and control
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  // Drive and capture
  output logic sda_oe,
  output logic [7:0] rx_byte
);
  int n = 0;
  initial sda_oe = 1'b0;
  initial rx_byte = 8'h00;
  // Start or stop restarts the bit count
  always @(sda) if (scl === 1'b1) n = 0;
  always @(posedge scl) begin
    if (n < 8) rx_byte = {rx_byte[6:0], sda};
    n = n + 1;
  end
  // Ack bit between the eighth and ninth falling edges
  always @(negedge scl) begin
    if (n == 8) sda_oe = !nack;
    if (n == 9) sda_oe = 1'b0;
    if (n == 9) n = 0;
  end
endmodule

// [dv/two_wire_master_tx_handshake_test.sv]
/* Bench for the master transmitter over its register bus.
   Assumes the slave model and open-drain wires with pull-ups. */
`timescale 1ns/100ps
module two_wire_master_tx_handshake_test;
  localparam logic [7:0] CT = twi_pkg::TWI_OFS_CTRL;
  localparam logic [7:0] ST = twi_pkg::TWI_OFS_STAT;
  localparam logic [7:0] DT = twi_pkg::TWI_OFS_DATA;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic nack = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, scl_out, sda_out, scl_oe, sda_oe, s_oe, op_done_irq;
  logic [7:0] rx_byte;
  int n_errors = 0;
  int tests_run = 0;
  wire scl = !scl_oe;
  wire sda = !(sda_oe || s_oe);
  always #4 ref_clk = !ref_clk;
  twi_master_tx u_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .op_done_irq(op_done_irq));
  twmth_slave_model u_slave (.scl(scl), .sda(sda), .nack(nack), .sda_oe(s_oe),
    .rx_byte(rx_byte));
  ////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    cmp("register", exp, rd);
  endtask
  // Software polls the done flag instead of taking the interrupt
  task automatic launch(input logic [7:0] c);
    bus(1'b1, CT, {24'h000000, c});
    do bus(1'b0, CT, 32'h00000000); while (rd[7] !== 1'b1);
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge ref_clk);
    n_errors++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd_cmp(CT, 32'h00000000);
    rd_cmp(ST, 32'h000000F8);
    rd_cmp(8'h0C, 32'h00000000);
    cmp("fixed outputs", 32'h1, {28'h0, hresp, scl_out, sda_out, hreadyout});
    bus(1'b1, DT, 32'h00000055);
    rd_cmp(CT, 32'h00000008);
    rd_cmp(DT, 32'h000000FF);
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      nack <= k[0];
      launch(8'hA5);
      rd_cmp(ST, 32'h00000008);
      bus(1'b1, DT, 32'h000000A4);
      if (k == 0) begin
        bus(1'b1, CT, 32'h00000005);
        repeat (5) @(posedge ref_clk);
        rd_cmp(CT, 32'h00000085);
        cmp("irq", 32'h1, {31'h0, op_done_irq});
      end
      launch(8'h85);
      rd_cmp(ST, k ? 32'h00000020 : 32'h00000018);
      cmp("address byte", 32'hA4, {24'h0, rx_byte});
      bus(1'b1, DT, 32'h0000003C);
      launch(8'h85);
      rd_cmp(ST, k ? 32'h00000030 : 32'h00000028);
      cmp("data byte", 32'h3C, {24'h0, rx_byte});
      if (k == 0) begin
        bus(1'b1, CT, 32'h00000004);
        repeat (3) @(posedge ref_clk);
        cmp("irq", 32'h0, {31'h0, op_done_irq});
      end
      bus(1'b1, CT, 32'h00000095);
      do bus(1'b0, CT, 32'h00000000); while (rd[4] !== 1'b0);
      cmp("control", 32'h00000005, rd);
      rd_cmp(ST, 32'h000000F8);
      $display("test transfer %0d done", k);
    end
    stop_test;
  end
endmodule
